// [slc_pkg.sv]
// Constants shared by the serial line console unit
package slc_pkg;
  // Clock and line timing
  localparam int unsigned CLK_HZ       = 50_000_000;
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned BAUD_DEF     = 9600;
  localparam int unsigned CLKS_PER_BIT_DEF = CLK_HZ / BAUD_DEF;
  localparam int unsigned BREAK_BITS   = 11;
  localparam int unsigned DATA_BITS    = 8;
  // Bus address layout
  localparam int unsigned ADDR_W       = 22;
  localparam int unsigned NARROW_W     = 18;
  localparam logic [3:0]  IO_TOP_22    = 4'hF;
  localparam logic [17:0] CONSOLE_BASE = 18'h3FF70;
  localparam logic [17:0] UNIT0_BASE   = 18'h3FD40;
  localparam logic [17:0] UNIT_STEP    = 18'h00008;
  // Register offsets inside one unit
  localparam logic [2:0]  OFF_RCSR     = 3'h0;
  localparam logic [2:0]  OFF_RBUF     = 3'h2;
  localparam logic [2:0]  OFF_TRANSMIT_STATUS_REG     = 3'h4;
  localparam logic [2:0]  OFF_TRANSMIT_HOLDING_BYTE     = 3'h6;
  // Field positions
  localparam int unsigned TRANSMIT_STATUS_REG_RDY_BIT = 7;
  localparam int unsigned TRANSMIT_STATUS_REG_IE_BIT  = 6;
  localparam int unsigned TRANSMIT_STATUS_REG_BRK_BIT = 0;
  localparam int unsigned RBUF_BRK_BIT = 11;
  // Vectors
  localparam logic [8:0]  VEC_CONSOLE  = 9'h030;
  localparam logic [8:0]  VEC_U0_DEF   = 9'h0C0;
  localparam logic [8:0]  VEC_U1_DEF   = 9'h0C8;
  localparam logic [8:0]  VEC_STEP     = 9'h008;
  // Reset values
  localparam logic [7:0]  HOLD_RST     = 8'h00;
  localparam logic [7:0]  BYTE_ZERO    = 8'h00;
  // Transmit shifter states
  typedef enum logic [3:0] {
    SLC_TX_IDLE  = 4'b0001,
    SLC_TX_START = 4'b0010,
    SLC_TX_DATA  = 4'b0100,
    SLC_TX_STOP  = 4'b1000
  } slc_tx_state_e;
endpackage

// [slc_console_unit.sv]
// Console serial line unit: transmit path, break detect and strap logic
//
// Function
// - Holding write stores byte, clears ready
// - Empty shifter and ready clear loads byte
// - Ready sets when byte enters shifter
// - Holding read returns byte, no side effect
// - Holding byte cleared at power-up
// - Console strap fixes address and vector
// - Without console strap, straps give addresses
// - Halt strap without reboot strap: received break halts processor
// - No halt strap: break never halts
// - Reboot strap without halt strap: break pulls power-good low
// - Width strap picks 22 or 18 bits
// - Ready and enable request an interrupt
// - Space for eleven bit times flags break
// - Break control holds output at space
`timescale 1ns/100ps
module slc_console_unit
  import slc_pkg::*;
#(
  parameter int unsigned CLKS_PER_BIT = CLKS_PER_BIT_DEF
) (
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              srst,
  // Host bus register access
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic              bus_rd,
  input  wire logic              bus_wr,
  input  wire logic [15:0]       bus_wdata,
  output logic      [15:0]       bus_rdata,
  output logic                   bus_reply,
  output logic                   irq_req,
  // Straps
  input  wire logic              console_strap,
  input  wire logic              halt_strap,
  input  wire logic              break_reboot_strap,
  input  wire logic              address_width_strap,
  input  wire logic [2:0]        unit_addr_strap,
  input  wire logic [4:0]        vector_strap,
  // Serial line
  input  wire logic              rx_serial,
  output logic                   tx_serial,
  // System actions and resolved map
  output logic                   halt_req,
  output logic                   dc_power_good_line_out,
  output logic                   dc_power_good_line_oe,
  output logic      [17:0]       unit0_base,
  output logic      [8:0]        unit0_vector,
  output logic      [17:0]       console_base,
  output logic      [8:0]        console_vector
);
  localparam int unsigned STRAP_W = 12;
  localparam logic [31:0] BIT_LAST = 32'(CLKS_PER_BIT - 1);
  localparam logic [31:0] BREAK_CYC = 32'(BREAK_BITS * CLKS_PER_BIT);
  localparam logic [2:0]  BIT_IDX_LAST = 3'(DATA_BITS - 1);

  logic [STRAP_W-1:0] strap_meta_reg, strap_reg;
  logic               rx_meta_reg, rx_reg;
  logic [7:0]         hold_reg, shift_reg;
  logic               ready_reg, ie_reg, brk_ctl_reg;
  logic               tx_line_reg, tx_line_next;
  slc_tx_state_e      tx_state_reg, tx_state_next;
  logic [31:0]        bit_cnt_reg;
  logic [2:0]         bit_idx_reg;
  logic [31:0]        brk_cnt_reg;
  logic               rx_brk_reg;
  logic [15:0]        rdata_reg;
  logic               reply_reg, halt_reg, reboot_reg;
  logic [17:0]        u0_base_reg, con_base_reg;
  logic [8:0]         u0_vec_reg, con_vec_reg;

  // Synchronised straps
  wire s_console = strap_reg[11];
  wire s_halt    = strap_reg[10];
  wire s_reboot  = strap_reg[9];
  wire s_large   = strap_reg[8];
  wire [2:0] s_usel = strap_reg[7:5];
  wire [4:0] s_vsel = strap_reg[4:0];

  // Address and vector selection from straps
  wire [17:0] u0_base_w  = UNIT0_BASE + {12'h000, s_usel, 3'h0};
  wire [17:0] u1_base_w  = u0_base_w + UNIT_STEP;
  wire [17:0] con_base_w = s_console ? CONSOLE_BASE : u1_base_w;
  wire [8:0]  vsel_vec   = {1'b0, s_vsel, 3'h0};
  wire [8:0]  u0_vec_w   = (s_vsel == 5'h00) ? VEC_U0_DEF : vsel_vec;
  wire [8:0]  u1_vec_w   = (s_vsel == 5'h00) ? VEC_U1_DEF : vsel_vec + VEC_STEP;
  wire [8:0]  con_vec_w  = s_console ? VEC_CONSOLE : u1_vec_w;

  // Address decode: 22 bits need the top nibble of the I/O page too
  wire top_ok   = !s_large || (bus_addr[21:18] == IO_TOP_22);
  wire unit_hit = top_ok && (bus_addr[17:3] == con_base_reg[17:3]);
  wire [2:0] off = bus_addr[2:0];
  wire hit_rcsr = unit_hit && (off == OFF_RCSR);
  wire hit_rbuf = unit_hit && (off == OFF_RBUF);
  wire hit_transmit_status_reg = unit_hit && (off == OFF_TRANSMIT_STATUS_REG);
  wire hit_transmit_holding_byte = unit_hit && (off == OFF_TRANSMIT_HOLDING_BYTE);
  wire wr_transmit_holding_byte  = bus_wr && hit_transmit_holding_byte;
  wire wr_transmit_status_reg  = bus_wr && hit_transmit_status_reg;
  wire any_hit  = hit_rcsr || hit_rbuf || hit_transmit_status_reg || hit_transmit_holding_byte;

  // Read data mux
  wire [15:0] transmit_status_reg_val = {8'h00, ready_reg, ie_reg, 5'h00, brk_ctl_reg};
  wire [15:0] rbuf_val = {4'h0, rx_brk_reg, 11'h000};
  wire [15:0] rd_mux   = hit_transmit_holding_byte ? {BYTE_ZERO, hold_reg} :
                         hit_transmit_status_reg ? transmit_status_reg_val :
                         hit_rbuf ? rbuf_val : 16'h0000;

  // Shifter load when empty and a byte is pending
  wire load = (tx_state_reg == SLC_TX_IDLE) && !ready_reg;
  wire bit_end = (bit_cnt_reg == BIT_LAST);

  // Break actions resolved against the exclusive straps
  wire halt_act   = s_halt && !s_reboot && rx_brk_reg;
  wire reboot_act = s_reboot && !s_halt && rx_brk_reg;

  // Strap and line synchronisers
  always_ff @(posedge core_clk) begin
    strap_meta_reg <= {console_strap, halt_strap, break_reboot_strap, address_width_strap,
                       unit_addr_strap, vector_strap};
    strap_reg      <= strap_meta_reg;
    rx_meta_reg    <= rx_serial;
    rx_reg         <= rx_meta_reg;
  end

  // Resolved map registers
  always_ff @(posedge core_clk) begin
    u0_base_reg  <= u0_base_w;
    u0_vec_reg   <= u0_vec_w;
    con_base_reg <= con_base_w;
    con_vec_reg  <= con_vec_w;
  end

  // Host registers; a write racing a load clears ready so the new byte follows
  always_ff @(posedge core_clk) begin
    if (srst) begin
      hold_reg    <= HOLD_RST;
      ready_reg   <= 1'b1;
      ie_reg      <= 1'b0;
      brk_ctl_reg <= 1'b0;
    end else begin
      if (wr_transmit_holding_byte) hold_reg <= bus_wdata[7:0];
      if (wr_transmit_holding_byte) ready_reg <= 1'b0;
      else if (load) ready_reg <= 1'b1;
      if (wr_transmit_status_reg) begin
        ie_reg      <= bus_wdata[TRANSMIT_STATUS_REG_IE_BIT];
        brk_ctl_reg <= bus_wdata[TRANSMIT_STATUS_REG_BRK_BIT];
      end
    end
  end

  // Bus answer one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (srst) begin
      reply_reg <= 1'b0;
      rdata_reg <= 16'h0000;
    end else begin
      reply_reg <= (bus_rd || bus_wr) && any_hit;
      if (bus_rd && any_hit) rdata_reg <= rd_mux;
    end
  end

  // Transmit shifter next state
  always_comb begin
    tx_state_next = tx_state_reg;
    tx_line_next  = 1'b1;
    case (tx_state_reg)
      SLC_TX_IDLE: begin
        if (load) tx_state_next = SLC_TX_START;
      end
      SLC_TX_START: begin
        tx_line_next = 1'b0;
        if (bit_end) tx_state_next = SLC_TX_DATA;
      end
      SLC_TX_DATA: begin
        tx_line_next = shift_reg[0];
        if (bit_end && bit_idx_reg == BIT_IDX_LAST) tx_state_next = SLC_TX_STOP;
      end
      SLC_TX_STOP: begin
        if (bit_end) tx_state_next = SLC_TX_IDLE;
      end
      default: tx_state_next = SLC_TX_IDLE;
    endcase
    if (tx_state_next == SLC_TX_START) tx_line_next = 1'b0;
    if (brk_ctl_reg) tx_line_next = 1'b0;
  end

  // Transmit shifter registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      tx_state_reg <= SLC_TX_IDLE;
      tx_line_reg  <= 1'b1;
      shift_reg    <= BYTE_ZERO;
      bit_cnt_reg  <= 32'h0000_0000;
      bit_idx_reg  <= 3'h0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_line_reg  <= tx_line_next;
      if (load) shift_reg <= hold_reg;
      else if (tx_state_reg == SLC_TX_DATA && bit_end) shift_reg <= {1'b0, shift_reg[7:1]};
      if (load || bit_end) bit_cnt_reg <= {31'h0000_0000, load}; // Start bit leaves on load
      else if (tx_state_reg != SLC_TX_IDLE) bit_cnt_reg <= bit_cnt_reg + 32'h0000_0001;
      if (load) bit_idx_reg <= 3'h0;
      else if (tx_state_reg == SLC_TX_DATA && bit_end) bit_idx_reg <= bit_idx_reg + 3'h1;
    end
  end

  // Break detect: space held for eleven bit times, cleared on mark
  always_ff @(posedge core_clk) begin
    if (srst) begin
      brk_cnt_reg <= 32'h0000_0000;
      rx_brk_reg  <= 1'b0;
    end else if (rx_reg) begin
      brk_cnt_reg <= 32'h0000_0000;
      rx_brk_reg  <= 1'b0;
    end else if (brk_cnt_reg != BREAK_CYC) begin
      brk_cnt_reg <= brk_cnt_reg + 32'h0000_0001;
    end else begin
      rx_brk_reg  <= 1'b1;
    end
  end

  // Halt and reboot action registers
  always_ff @(posedge core_clk) begin
    if (srst) begin
      halt_reg   <= 1'b0;
      reboot_reg <= 1'b0;
    end else begin
      halt_reg   <= halt_act;
      reboot_reg <= reboot_act;
    end
  end

  // Outputs
  assign bus_rdata              = rdata_reg;
  assign bus_reply              = reply_reg;
  assign irq_req                = ie_reg && ready_reg;
  assign tx_serial              = tx_line_reg;
  assign halt_req               = halt_reg;
  assign dc_power_good_line_out = 1'b0;
  assign dc_power_good_line_oe  = reboot_reg;
  assign unit0_base             = u0_base_reg;
  assign unit0_vector           = u0_vec_reg;
  assign console_base           = con_base_reg;
  assign console_vector         = con_vec_reg;

  // Checks
  a_write_clears_rdy: assert property (@(posedge core_clk) disable iff (srst)
    wr_transmit_holding_byte |=> !ready_reg && hold_reg == $past(bus_wdata[7:0]))
    else $error("holding write did not clear ready");
  a_load_sets_rdy: assert property (@(posedge core_clk) disable iff (srst)
    load && !wr_transmit_holding_byte |=> ready_reg && shift_reg == $past(hold_reg)
      && tx_state_reg == SLC_TX_START)
    else $error("load did not set ready");
  a_pending_loads: assert property (@(posedge core_clk) disable iff (srst)
    tx_state_reg == SLC_TX_IDLE && !ready_reg |=> tx_state_reg == SLC_TX_START)
    else $error("pending byte not loaded");
  a_transmit_holding_byte_readback: assert property (@(posedge core_clk) disable iff (srst)
    bus_rd && hit_transmit_holding_byte && !bus_wr |=> bus_reply && bus_rdata == {BYTE_ZERO, $past(hold_reg)}
      && ready_reg == $past(ready_reg))
    else $error("holding read wrong");
  a_reset_hold: assert property (@(posedge core_clk)
    srst |=> hold_reg == HOLD_RST && ready_reg)
    else $error("holding byte not cleared");
  a_console_map: assert property (@(posedge core_clk) disable iff (srst)
    s_console |=> console_base == CONSOLE_BASE && console_vector == VEC_CONSOLE)
    else $error("console map wrong");
  a_strap_map: assert property (@(posedge core_clk) disable iff (srst)
    !s_console |=> console_base == unit0_base + UNIT_STEP)
    else $error("strap map wrong");
  a_halt_on_break: assert property (@(posedge core_clk) disable iff (srst)
    s_halt && !s_reboot && rx_brk_reg |=> halt_req)
    else $error("break did not halt");
  a_no_halt: assert property (@(posedge core_clk) disable iff (srst)
    !$past(s_halt) |-> !halt_req)
    else $error("halt without strap");
  a_reboot_line: assert property (@(posedge core_clk) disable iff (srst)
    s_reboot && !s_halt && rx_brk_reg |=> dc_power_good_line_oe && !dc_power_good_line_out)
    else $error("reboot not driven");
  a_narrow_decode: assert property (@(posedge core_clk) disable iff (srst)
    !s_large && bus_rd && bus_addr[17:3] == con_base_reg[17:3] |=> bus_reply)
    else $error("18-bit decode missed");
  a_irq_level: assert property (@(posedge core_clk) disable iff (srst)
    $rose(ready_reg) && ie_reg |-> irq_req)
    else $error("interrupt missing");
  a_break_time: assert property (@(posedge core_clk) disable iff (srst)
    $rose(rx_brk_reg) |-> $past(brk_cnt_reg) == BREAK_CYC && !$past(rx_reg))
    else $error("break flagged early");
  a_break_space: assert property (@(posedge core_clk) disable iff (srst)
    brk_ctl_reg |=> !tx_serial)
    else $error("break control not space");
  a_start_bit: assert property (@(posedge core_clk) disable iff (srst)
    tx_state_reg == SLC_TX_IDLE && load |=> !tx_serial)
    else $error("no start bit");
  a_exclusive: assert property (@(posedge core_clk) disable iff (srst)
    s_halt && s_reboot |=> !halt_req && !dc_power_good_line_oe)
    else $error("both break actions");
endmodule

// [slc_host_model.sv]
// Host processor model that issues register cycles on the bus
`timescale 1ns/100ps
module slc_host_model
  import slc_pkg::*;
(
  // Clock
  input  wire logic              core_clk,
  // Bus request side
  output logic      [ADDR_W-1:0] bus_addr,
  output logic                   bus_rd,
  output logic                   bus_wr,
  output logic      [15:0]       bus_wdata,
  // Bus answer side
  input  wire logic [15:0]       bus_rdata,
  input  wire logic              bus_reply
);
  initial begin
    bus_addr  = '0;
    bus_rd    = 1'b0;
    bus_wr    = 1'b0;
    bus_wdata = '0;
  end
  // One strobe pulse, released lines show the inverse so stale values never pass
  task automatic acc(input logic rd, input logic [ADDR_W-1:0] a, input logic [15:0] wd,
                     output logic [15:0] rv, output logic ok);
    @(posedge core_clk);
    bus_addr  <= a;
    bus_wdata <= wd;
    bus_rd    <= rd;
    bus_wr    <= ~rd;
    @(posedge core_clk);
    bus_rd    <= 1'b0;
    bus_wr    <= 1'b0;
    bus_addr  <= ~a;
    bus_wdata <= ~wd;
    // Reply arrives exactly one cycle after the strobe edge
    @(posedge core_clk);
    ok = bus_reply;
    rv = bus_rdata;
  endtask
endmodule

// [serial_line_console_unit_tb.sv]
// Self-checking bench for the console serial line unit
`timescale 1ns/100ps
module serial_line_console_unit_tb;
  import slc_pkg::*;
  localparam int CPB = 8;
  logic core_clk = 1'b0, srst = 1'b1, rx_serial = 1'b1;
  logic console_strap = 1'b1, halt_strap = 1'b0, break_reboot_strap = 1'b0;
  logic address_width_strap = 1'b1;
  logic [2:0] unit_addr_strap = 3'h0;
  logic [4:0] vector_strap = 5'h00;
  logic [ADDR_W-1:0] bus_addr;
  logic bus_rd, bus_wr, bus_reply, irq_req, tx_serial, halt_req, pg_out, pg_oe;
  logic [15:0] bus_wdata, bus_rdata, rv;
  logic [17:0] unit0_base, console_base;
  logic [8:0] unit0_vector, console_vector;
  logic ok;
  logic [7:0] a, b, g;
  int errors = 0, n_tests = 0, seed, i, k;

  slc_console_unit #(.CLKS_PER_BIT(CPB)) DUT (.core_clk(core_clk), .srst(srst),
    .bus_addr(bus_addr), .bus_rd(bus_rd), .bus_wr(bus_wr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_reply(bus_reply), .irq_req(irq_req),
    .console_strap(console_strap), .halt_strap(halt_strap),
    .break_reboot_strap(break_reboot_strap), .address_width_strap(address_width_strap),
    .unit_addr_strap(unit_addr_strap), .vector_strap(vector_strap), .rx_serial(rx_serial),
    .tx_serial(tx_serial), .halt_req(halt_req), .dc_power_good_line_out(pg_out),
    .dc_power_good_line_oe(pg_oe), .unit0_base(unit0_base), .unit0_vector(unit0_vector),
    .console_base(console_base), .console_vector(console_vector));
  slc_host_model HOST (.core_clk(core_clk), .bus_addr(bus_addr), .bus_rd(bus_rd),
    .bus_wr(bus_wr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_reply(bus_reply));

  // Clock at 50 MHz
  initial begin
    forever #10 core_clk = ~core_clk;
  end
  // Expected map values
  function automatic logic [17:0] base0(input logic [2:0] s);
    return UNIT0_BASE + UNIT_STEP * 18'(s);
  endfunction
  function automatic logic [8:0] vec(input logic [4:0] v, input logic u1);
    if (v == 5'h00) return u1 ? VEC_U1_DEF : VEC_U0_DEF;
    return (9'(v) << 3) + (u1 ? VEC_STEP : 9'h000);
  endfunction
  function automatic logic [ADDR_W-1:0] ad(input logic [2:0] off);
    return {IO_TOP_22, CONSOLE_BASE[17:3], off};
  endfunction
  task automatic final_report();
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] s);
    n_tests++;
    if (s !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Capture one serial frame, sampling each bit in its middle
  task automatic get_frame(output logic [7:0] d);
    int n;
    for (n = 0; n < 300 && tx_serial !== 1'b0; n++) @(posedge core_clk);
    if (n == 300) begin
      errors++;
      $display("MISMATCH frame start expected 0 seen %b", tx_serial);
      final_report();
    end
    repeat (CPB / 2 - 1) @(posedge core_clk);
    chk("start bit", 18'h0, 18'(tx_serial));
    for (n = 0; n < 8; n++) begin
      repeat (CPB) @(posedge core_clk);
      d[n] = tx_serial;
    end
    repeat (CPB) @(posedge core_clk);
    chk("stop bit", 18'h1, 18'(tx_serial));
  endtask

  initial begin
    seed = 78642;
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    chk("tx idle", 18'h1, 18'(tx_serial));
    HOST.acc(1'b1, ad(OFF_TRANSMIT_HOLDING_BYTE), 16'h0000, rv, ok);
    chk("hold reset", 18'h0, 18'(rv));
    HOST.acc(1'b1, ad(OFF_TRANSMIT_STATUS_REG), 16'h0000, rv, ok);
    chk("status reset", 18'h80, 18'(rv));
    $display("test reset done");
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk);
      unit_addr_strap <= 3'($random(seed));
      vector_strap <= (i == 0) ? 5'h00 : 5'($random(seed));
      console_strap <= i[0];
      repeat (4) @(posedge core_clk);
      chk("unit0 base", base0(unit_addr_strap), unit0_base);
      chk("unit0 vector", 18'(vec(vector_strap, 1'b0)), 18'(unit0_vector));
      chk("console base", console_strap ? CONSOLE_BASE : base0(unit_addr_strap) + UNIT_STEP,
          console_base);
      chk("console vector", 18'(console_strap ? VEC_CONSOLE : vec(vector_strap, 1'b1)),
          18'(console_vector));
    end
    $display("test map done");
    HOST.acc(1'b1, {4'h3, CONSOLE_BASE[17:3], OFF_TRANSMIT_STATUS_REG}, 16'h0000, rv, ok);
    chk("wide miss", 18'h0, 18'(ok));
    address_width_strap <= 1'b0;
    repeat (4) @(posedge core_clk);
    HOST.acc(1'b1, {4'($random(seed)), CONSOLE_BASE[17:3], OFF_TRANSMIT_STATUS_REG}, 16'h0, rv, ok);
    chk("narrow hit", 18'h1, 18'(ok));
    address_width_strap <= 1'b1;
    repeat (4) @(posedge core_clk);
    HOST.acc(1'b0, ad(OFF_TRANSMIT_HOLDING_BYTE) + 22'h8, 16'h0055, rv, ok);
    chk("unmapped", 18'h0, 18'(ok));
    HOST.acc(1'b1, ad(OFF_TRANSMIT_HOLDING_BYTE), 16'h0000, rv, ok);
    chk("hold kept", 18'h0, 18'(rv));
    $display("test decode done");
    HOST.acc(1'b0, ad(OFF_TRANSMIT_STATUS_REG), 16'h0040, rv, ok);
    chk("irq on", 18'h1, 18'(irq_req));
    for (i = 0; i < 3; i++) begin
      a = (i == 0) ? 8'h00 : 8'($random(seed));
      b = (i == 0) ? 8'hFF : 8'($random(seed));
      HOST.acc(1'b0, ad(OFF_TRANSMIT_HOLDING_BYTE), {8'($random(seed)), a}, rv, ok);
      fork
        HOST.acc(1'b0, ad(OFF_TRANSMIT_HOLDING_BYTE), {8'($random(seed)), b}, rv, ok);
        get_frame(g);
      join
      chk("frame a", 18'(a), 18'(g));
      chk("ready held", 18'h0, 18'(irq_req));
      get_frame(g);
      chk("frame b", 18'(b), 18'(g));
      chk("ready set", 18'h1, 18'(irq_req));
      for (k = 0; k < 2; k++) begin
        HOST.acc(1'b1, ad(OFF_TRANSMIT_HOLDING_BYTE), 16'h0000, rv, ok);
        chk("hold read", 18'(b), 18'(rv));
      end
    end
    $display("test transmit done");
    HOST.acc(1'b0, ad(OFF_TRANSMIT_STATUS_REG), 16'h0041, rv, ok);
    for (k = 0; k < 30; k++) begin
      @(posedge core_clk);
      chk("break out", 18'h0, 18'(tx_serial));
    end
    HOST.acc(1'b0, ad(OFF_TRANSMIT_STATUS_REG), 16'h0000, rv, ok);
    HOST.acc(1'b1, ad(OFF_TRANSMIT_STATUS_REG), 16'h0000, rv, ok);
    chk("status ro", 18'h80, 18'(rv));
    chk("tx released", 18'h1, 18'(tx_serial));
    chk("irq off", 18'h0, 18'(irq_req));
    $display("test break out done");
    for (i = 0; i < 4; i++) begin
      halt_strap <= i[0];
      break_reboot_strap <= i[1];
      repeat (4) @(posedge core_clk);
      rx_serial <= 1'b0;
      repeat (11 * CPB) @(posedge core_clk);
      chk("early halt", 18'h0, 18'(halt_req));
      repeat (6) @(posedge core_clk);
      chk("halt", 18'(i == 1), 18'(halt_req));
      chk("reboot", 18'(i == 2), 18'(pg_oe));
      chk("pg level", 18'h0, 18'(pg_out));
      HOST.acc(1'b1, ad(OFF_RBUF), 16'h0000, rv, ok);
      chk("rx break", 18'h1, 18'(rv[RBUF_BRK_BIT]));
      rx_serial <= 1'b1;
      repeat (6) @(posedge core_clk);
      chk("halt clear", 18'h0, 18'({halt_req, pg_oe}));
      HOST.acc(1'b1, ad(OFF_RBUF), 16'h0000, rv, ok);
      chk("rx mark", 18'h0, 18'(rv[RBUF_BRK_BIT]));
    end
    $display("test break in done");
    HOST.acc(1'b0, ad(OFF_TRANSMIT_HOLDING_BYTE), 16'h00A5, rv, ok);
    srst <= 1'b1;
    repeat (3) @(posedge core_clk);
    srst <= 1'b0;
    chk("tx after reset", 18'h1, 18'(tx_serial));
    HOST.acc(1'b1, ad(OFF_TRANSMIT_HOLDING_BYTE), 16'h0000, rv, ok);
    chk("hold cleared", 18'h0, 18'(rv));
    HOST.acc(1'b1, ad(OFF_TRANSMIT_STATUS_REG), 16'h0000, rv, ok);
    chk("status after reset", 18'h80, 18'(rv));
    $display("test reset again done");
    final_report();
  end
endmodule
